// File: src/apg_top.sv
// Summary of operation
// - Each bank holds four PWM channels, each generated inside and running on its own.
// - Every channel output is a separate bit of its bank's output port so routing can hand it to any destination.
// - A per-channel selector takes the repeat interval from a rate or from an interval.
// - A per-channel selector takes the high time from a percentage or an absolute width.
// - Only the field picked by the selector is used and the other is ignored.
// - In rate format the interval is derived from a value in hertz, 100 Hz by default.
// - In interval format the interval is taken from a value in ms, 10 ms by default.
// - In percentage format the high time is that share of the interval, 50 by default.
// - In width format the high time is an absolute time in ms, 5 ms by default.
// - A second expansion bank of four channels offers the same formats on its own port.
//
// Decided for this implementation: the register addresses and register access over AHB-Lite.
module apg_top
   import apg_pkg::*;
#(
   parameter int BANK_CH = CH_PER_BANK,
   parameter int TICK_DIV = TICK_CYCLES
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic [BANK_CH-1:0] aux_pwm_out,
   output logic [BANK_CH-1:0] ext_pwm_out
);
   localparam int NCH = NUM_BANKS * BANK_CH;
   localparam int TW = $clog2(TICK_DIV);

   // Time base
   logic [TW-1:0] tick_cnt_reg;
   logic tick_reg;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         tick_cnt_reg <= '0;
         tick_reg <= 1'b0;
      end
      else
      begin
         tick_reg <= (tick_cnt_reg == TW'(TICK_DIV - 1));
         tick_cnt_reg <= (tick_cnt_reg == TW'(TICK_DIV - 1)) ? '0 : tick_cnt_reg + 1'b1;
      end
   end

   // Bus address phase capture
   wire addr_phase = hsel && hready && htrans[1];
   logic wr_pend_reg;
   logic [11:0] wr_addr_reg;
   logic [31:0] rdata_reg;

   wire [11:0] a_off = haddr[11:0];
   wire [2:0] a_ch = a_off[7:5];
   wire [11:0] a_reg = {7'h00, a_off[4:0]};
   wire a_is_status = (a_off == REG_STATUS);
   wire a_in_ch = (a_off[11:8] == 4'h0) && (32'(a_ch) < NCH);

   wire [2:0] w_ch = wr_addr_reg[7:5];
   wire [11:0] w_reg = {7'h00, wr_addr_reg[4:0]};
   wire w_in_ch = (wr_addr_reg[11:8] == 4'h0) && (32'(w_ch) < NCH);

   apg_cfg_t cfg_reg [NCH];
   logic [NCH-1:0] pwm_all;

   // Read data selection
   apg_cfg_t rd_cfg;
   assign rd_cfg = a_in_ch ? cfg_reg[a_ch] : '0;
   wire [31:0] rd_ctrl = {30'h0000_0000, rd_cfg.high_time_format_select,
                          rd_cfg.repeat_format_select};
   logic [31:0] rd_word;

   // Read word for the address being taken
   always_comb
   begin
      rd_word = 32'h0000_0000;
      if (a_is_status)
         rd_word = {{(32 - NCH){1'b0}}, pwm_all};
      else if (!a_in_ch)
         rd_word = 32'h0000_0000;
      else if (a_reg == REG_CTRL)
         rd_word = rd_ctrl;
      else if (a_reg == REG_RATE)
         rd_word = {16'h0000, rd_cfg.repeat_rate_hz};
      else if (a_reg == REG_INTERVAL)
         rd_word = {16'h0000, rd_cfg.repeat_interval_ms};
      else if (a_reg == REG_PCT)
         rd_word = {24'h00_0000, rd_cfg.high_time_percent};
      else if (a_reg == REG_WIDTH)
         rd_word = {16'h0000, rd_cfg.high_time_ms};
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= '0;
         rdata_reg <= '0;
      end
      else
      begin
         wr_pend_reg <= addr_phase && hwrite;
         if (addr_phase)
            wr_addr_reg <= a_off;
         if (addr_phase && !hwrite)
            rdata_reg <= rd_word;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_reg;

   // Per-channel settings, timing computation and waveform
   genvar i;
   generate
      for (i = 0; i < NCH; i++)
      begin : g_ch
         wire sel = wr_pend_reg && w_in_ch && (w_ch == 3'(i));
         apg_state_t state_reg;
         apg_timing_t pend_reg;
         logic [CNT_W-1:0] period_tmp_reg;
         logic [DIV_W-1:0] quo;
         logic div_done;
         logic [DIV_W-1:0] num;
         logic [DIV_W-1:0] den;
         logic den_zero_reg;

         // Settings store
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
            begin
               cfg_reg[i].repeat_format_select <= RPT_RATE;
               cfg_reg[i].high_time_format_select <= HT_PERCENT;
               cfg_reg[i].repeat_rate_hz <= DEF_RATE_HZ;
               cfg_reg[i].repeat_interval_ms <= DEF_INTERVAL_MS;
               cfg_reg[i].high_time_percent <= DEF_PCT;
               cfg_reg[i].high_time_ms <= DEF_WIDTH_MS;
            end
            else if (sel)
            begin
               if (w_reg == REG_CTRL)
               begin
                  cfg_reg[i].repeat_format_select <=
                     apg_repeat_fmt_t'(hwdata[CTRL_REPEAT_BIT]);
                  cfg_reg[i].high_time_format_select <=
                     apg_high_fmt_t'(hwdata[CTRL_HIGH_BIT]);
               end
               else if (w_reg == REG_RATE)
                  cfg_reg[i].repeat_rate_hz <= hwdata[15:0];
               else if (w_reg == REG_INTERVAL)
                  cfg_reg[i].repeat_interval_ms <= hwdata[15:0];
               else if (w_reg == REG_PCT)
                  cfg_reg[i].high_time_percent <= hwdata[7:0];
               else if (w_reg == REG_WIDTH)
                  cfg_reg[i].high_time_ms <= hwdata[15:0];
            end
         end

         // Operand selection; only the selected field feeds the divider
         wire use_rate = (cfg_reg[i].repeat_format_select == RPT_RATE);
         wire use_pct = (cfg_reg[i].high_time_format_select == HT_PERCENT);
         wire [DIV_W-1:0] rate_num = DIV_W'(TICK_HZ);
         wire [DIV_W-1:0] rate_den = {16'h0000, cfg_reg[i].repeat_rate_hz};
         wire [DIV_W-1:0] intv_num =
            DIV_W'(cfg_reg[i].repeat_interval_ms) * DIV_W'(TICKS_PER_MS);
         wire [7:0] pct_lim = (cfg_reg[i].high_time_percent > 8'(PCT_FULL)) ?
                              8'(PCT_FULL) : cfg_reg[i].high_time_percent;
         wire [DIV_W-1:0] quo_den_zero = den_zero_reg ? '0 : quo;
         wire [CNT_W-1:0] quo_sat = (quo_den_zero[DIV_W-1:CNT_W] != '0) ?
                                    {CNT_W{1'b1}} : quo_den_zero[CNT_W-1:0];
         wire [DIV_W-1:0] pct_num = DIV_W'(quo_sat) * DIV_W'(pct_lim);
         wire [DIV_W-1:0] abs_num =
            DIV_W'(cfg_reg[i].high_time_ms) * DIV_W'(TICKS_PER_MS);

         wire in_idle = (state_reg == ST_IDLE);
         wire div_go = in_idle || ((state_reg == ST_RATE) && div_done);

         assign num = in_idle ? (use_rate ? rate_num : intv_num) :
                      (use_pct ? pct_num : abs_num);
         assign den = in_idle ? (use_rate ? rate_den : DIV_W'(1)) :
                      (use_pct ? DIV_W'(PCT_FULL) : DIV_W'(1));

         apg_div #(.W(DIV_W)) u_div (
            .hclk(hclk),
            .hresetn(hresetn),
            .start(div_go),
            .num(num),
            .den(den),
            .quo(quo),
            .busy(),
            .done(div_done)
         );

         // Continuous recompute of pending interval and high time
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
            begin
               state_reg <= ST_IDLE;
               pend_reg <= '0;
               period_tmp_reg <= '0;
               den_zero_reg <= 1'b0;
            end
            else
            begin
               // Zero divisor noted at start, so 0 Hz yields a zero interval
               if (div_go)
                  den_zero_reg <= (den == '0);
               case (state_reg)
                  ST_IDLE:
                     state_reg <= ST_RATE;
                  ST_RATE:
                     if (div_done)
                     begin
                        period_tmp_reg <= quo_sat;
                        state_reg <= ST_HIGH;
                     end
                  ST_HIGH:
                     if (div_done)
                     begin
                        pend_reg.period <= period_tmp_reg;
                        pend_reg.high <= quo_sat;
                        state_reg <= ST_IDLE;
                     end
                  default:
                     state_reg <= ST_IDLE;
               endcase
            end
         end

         // Independent waveform generator
         apg_chan u_chan (
            .hclk(hclk),
            .hresetn(hresetn),
            .tick(tick_reg),
            .pend(pend_reg),
            .pwm_out(pwm_all[i])
         );
      end
   endgenerate

   // Main bank and expansion bank outputs for routing
   assign aux_pwm_out = pwm_all[BANK_CH-1:0];
   assign ext_pwm_out = pwm_all[NCH-1:BANK_CH];
endmodule

// File: shared/apg_pkg.sv
package apg_pkg;
   // Clock and time base
   localparam int CLK_PERIOD_NS = 25;
   localparam int TICK_PERIOD_NS = 10000;
   localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int TICK_HZ = 1000000000 / TICK_PERIOD_NS;
   localparam int TICKS_PER_MS = 1000000 / TICK_PERIOD_NS;
   localparam int PCT_FULL = 100;

   // Channel organisation
   localparam int CH_PER_BANK = 4;
   localparam int NUM_BANKS = 2;
   localparam int CNT_W = 24;
   localparam int DIV_W = 32;

   // Register map, byte addresses
   localparam logic [11:0] CH_STRIDE = 12'h0020;
   localparam logic [11:0] REG_CTRL = 12'h0000;
   localparam logic [11:0] REG_RATE = 12'h0004;
   localparam logic [11:0] REG_INTERVAL = 12'h0008;
   localparam logic [11:0] REG_PCT = 12'h000c;
   localparam logic [11:0] REG_WIDTH = 12'h0010;
   localparam logic [11:0] REG_STATUS = 12'h0100;

   // Control field positions
   localparam int CTRL_REPEAT_BIT = 0;
   localparam int CTRL_HIGH_BIT = 1;

   // Reset values
   localparam logic [15:0] DEF_RATE_HZ = 16'h0064;
   localparam logic [15:0] DEF_INTERVAL_MS = 16'h000a;
   localparam logic [7:0] DEF_PCT = 8'h32;
   localparam logic [15:0] DEF_WIDTH_MS = 16'h0005;

   typedef enum logic {RPT_RATE = 1'b0, RPT_INTERVAL = 1'b1} apg_repeat_fmt_t;
   typedef enum logic {HT_PERCENT = 1'b0, HT_ABS = 1'b1} apg_high_fmt_t;
   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_RATE = 2'b01, ST_HIGH = 2'b11} apg_state_t;

   typedef struct packed {
      apg_repeat_fmt_t repeat_format_select;
      apg_high_fmt_t high_time_format_select;
      logic [15:0] repeat_rate_hz;
      logic [15:0] repeat_interval_ms;
      logic [7:0] high_time_percent;
      logic [15:0] high_time_ms;
   } apg_cfg_t;

   typedef struct packed {
      logic [CNT_W-1:0] period;
      logic [CNT_W-1:0] high;
   } apg_timing_t;
endpackage

// File: src/apg_div.sv
module apg_div
   import apg_pkg::*;
#(
   parameter int W = DIV_W
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic start,
   input wire logic [W-1:0] num,
   input wire logic [W-1:0] den,
   output logic [W-1:0] quo,
   output logic busy,
   output logic done
);
   logic [W-1:0] quo_reg;
   logic [W:0] rem_reg;
   logic [W-1:0] den_reg;
   logic [$clog2(W+1)-1:0] cnt_reg;
   logic busy_reg;
   logic done_reg;

   // One restoring step per cycle
   wire [W:0] shifted = {rem_reg[W-1:0], quo_reg[W-1]};
   wire [W:0] diff = shifted - {1'b0, den_reg};
   wire fits = !diff[W];
   wire [W:0] rem_next = fits ? diff : shifted;
   wire [W-1:0] quo_next = {quo_reg[W-2:0], fits};

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         quo_reg <= '0;
         rem_reg <= '0;
         den_reg <= '0;
         cnt_reg <= '0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end
      else
      begin
         done_reg <= 1'b0;
         if (start && !busy_reg)
         begin
            quo_reg <= num;
            rem_reg <= '0;
            den_reg <= den;
            cnt_reg <= ($clog2(W+1))'(W);
            busy_reg <= 1'b1;
         end
         else if (busy_reg)
         begin
            quo_reg <= quo_next;
            rem_reg <= rem_next;
            cnt_reg <= cnt_reg - 1'b1;
            if (cnt_reg == 1)
            begin
               busy_reg <= 1'b0;
               done_reg <= 1'b1;
            end
         end
      end
   end

   assign quo = quo_reg;
   assign busy = busy_reg;
   assign done = done_reg;
endmodule

// File: src/apg_chan.sv
module apg_chan
   import apg_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic tick,
   input apg_timing_t pend,
   output logic pwm_out
);
   apg_timing_t cur_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic out_reg;

   wire [CNT_W-1:0] cnt_inc = cnt_reg + 1'b1;
   wire at_end = (cnt_inc >= cur_reg.period);
   wire reload = tick && (at_end || cur_reg.period == '0);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cur_reg <= '0;
         cnt_reg <= '0;
         out_reg <= 1'b0;
      end
      else
      begin
         if (reload)
         begin
            // New settings only at an interval boundary
            cur_reg <= pend;
            cnt_reg <= '0;
         end
         else if (tick)
            cnt_reg <= cnt_inc;
         // High while count below high time; full or zero high follow
         out_reg <= (cur_reg.period != '0) && (cnt_reg < cur_reg.high);
      end
   end

   assign pwm_out = out_reg;
endmodule

// File: test/apg_top_sva.sv
module apg_top_chk
   import apg_pkg::*;
#(
   parameter int BANK_CH = CH_PER_BANK,
   parameter int TICK_DIV = TICK_CYCLES
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic [BANK_CH-1:0] aux_pwm_out,
   input wire logic [BANK_CH-1:0] ext_pwm_out
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic [BANK_CH-1:0] aux_prev;
   logic [BANK_CH-1:0] ext_prev;
   logic [15:0] aux_age;
   logic [15:0] ext_age;
   wire logic rd_take = hsel && hready && htrans[1] && !hwrite;
   wire logic [11:0] ofs = haddr[11:0];
   wire logic unmapped = (ofs > REG_STATUS) || (ofs < REG_STATUS && ofs[4:0] > 5'h10);
   wire logic [2*BANK_CH-1:0] lvl = {ext_pwm_out, aux_pwm_out};
   // Cycles since each bank's outputs last moved
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         aux_prev <= '0;
         ext_prev <= '0;
         aux_age <= '0;
         ext_age <= '0;
      end
      else
      begin
         aux_prev <= aux_pwm_out;
         ext_prev <= ext_pwm_out;
         aux_age <= (aux_pwm_out != aux_prev) ? 16'h0000 : aux_age + 16'(aux_age != 16'hffff);
         ext_age <= (ext_pwm_out != ext_prev) ? 16'h0000 : ext_age + 16'(ext_age != 16'hffff);
      end
   end
   ready_high_a: assert property (hreadyout) else $error("hreadyout low");
   resp_okay_a: assert property (!hresp) else $error("error response");
   aux_tick_a: assert property (aux_pwm_out != aux_prev |-> aux_age >= 16'(TICK_DIV - 1))
      else $error("main bank moved off a tick");
   ext_tick_a: assert property (ext_pwm_out != ext_prev |-> ext_age >= 16'(TICK_DIV - 1))
      else $error("expansion bank moved off a tick");
   reset_low_a: assert property ($rose(hresetn) |-> lvl == '0)
      else $error("outputs not low after reset");
   status_read_a: assert property (rd_take && ofs == REG_STATUS |=>
      hrdata[2*BANK_CH-1:0] == $past(lvl) || hrdata[2*BANK_CH-1:0] == lvl)
      else $error("status does not show levels");
   unmapped_zero_a: assert property (rd_take && unmapped |=> hrdata == '0)
      else $error("unmapped read not zero");
   rdata_hold_a: assert property (!rd_take |=> $stable(hrdata))
      else $error("read data moved without read");
   cover property (rd_take && ofs == REG_STATUS);
   cover property (aux_pwm_out != aux_prev);
   cover property (ext_pwm_out != ext_prev);
endmodule

bind apg_top apg_top_chk #(.BANK_CH(BANK_CH), .TICK_DIV(TICK_DIV)) chk (.hclk(hclk),
   .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .hrdata(hrdata), .aux_pwm_out(aux_pwm_out), .ext_pwm_out(ext_pwm_out));

// File: test/apg_route_model.sv
module apg_route_model
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [3:0] aux_pwm,
   input wire logic [3:0] ext_pwm
);
   timeunit 1ns;
   timeprecision 100ps;
   wire logic [7:0] lvl = {ext_pwm, aux_pwm};
   logic [7:0] prev;
   int t;
   int last [8];
   int period [8];
   int high [8];
   int rises [8];
   // Each destination times its rising and falling edges
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         prev <= '0;
         rises <= '{default: 0};
      end
      else
      begin
         t <= t + 1;
         prev <= lvl;
         for (int i = 0; i < 8; i++)
         begin
            if (lvl[i] && !prev[i])
            begin
               period[i] <= t - last[i];
               last[i] <= t;
               rises[i] <= rises[i] + 1;
            end
            if (!lvl[i] && prev[i])
               high[i] <= t - last[i];
         end
      end
   end
endmodule

// File: test/apg_top_test.sv
module apg_top_test
   import apg_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int TDIV = 4;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = '0;
   logic [1:0] htrans = '0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = '0;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic [3:0] aux;
   logic [3:0] ext;
   int errors = 0;
   int compares = 0;
   int cyc = 0;
   int exp_per [8];
   int exp_hi [8];
   logic [31:0] seed = 32'h32fa_b17a;

   always #12.5 hclk = ~hclk;

   apg_top #(.TICK_DIV(TDIV)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .aux_pwm_out(aux), .ext_pwm_out(ext));
   apg_route_model route (.hclk(hclk), .hresetn(hresetn), .aux_pwm(aux), .ext_pwm(ext));

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task print_verdict();
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One single AHB transfer, called just after a rising edge
   task ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {20'h0_0000, a};
      htrans <= 2'b10;
      hwrite <= wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask

   task rdc(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] r;
      ahb(1'b0, a, 32'h0, r);
      chk(r, e);
   endtask

   task wrc(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      ahb(1'b1, a, d, r);
      rdc(a, d);
   endtask

   always @(posedge hclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 60000)
      begin
         errors++;
         print_verdict();
      end
   end

   initial
   begin
      logic [31:0] r;
      logic [11:0] b;
      int rate, ms, pct, wid, per, hi, n;
      int snap [8];
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int i = 0; i < 8; i++)
      begin
         b = 12'(i) * CH_STRIDE;
         rdc(b + REG_CTRL, 32'h0);
         rdc(b + REG_RATE, {16'h0000, DEF_RATE_HZ});
         rdc(b + REG_INTERVAL, {16'h0000, DEF_INTERVAL_MS});
         rdc(b + REG_PCT, {24'h00_0000, DEF_PCT});
         rdc(b + REG_WIDTH, {16'h0000, DEF_WIDTH_MS});
      end
      rdc(12'h014, 32'h0);
      rdc(12'h104, 32'h0);
      repeat (9000) @(posedge hclk);
      chk(32'(route.period[6]), 32'(TICK_HZ / 100 * TDIV));
      chk(32'(route.high[6]), 32'(TICK_HZ / 200 * TDIV));
      for (int i = 0; i < 8; i++)
      begin
         b = 12'(i) * CH_STRIDE;
         rate = 200 + xs() % 700;
         ms = 2 + xs() % 3;
         pct = 10 + xs() % 81;
         wid = i[0] ? 1 + xs() % (ms - 1) : 1;
         if (i == 3) wid = ms + 1;
         if (i == 4) pct = 0;
         if (i == 5) pct = 150;
         wrc(b + REG_CTRL, 32'(i % 4));
         wrc(b + REG_RATE, 32'(rate));
         wrc(b + REG_INTERVAL, 32'(ms));
         wrc(b + REG_PCT, 32'(pct));
         wrc(b + REG_WIDTH, 32'(wid));
         per = i[0] ? ms * TICKS_PER_MS : TICK_HZ / rate;
         hi = i[1] ? wid * TICKS_PER_MS : per * (pct > PCT_FULL ? PCT_FULL : pct) / PCT_FULL;
         exp_per[i] = per * TDIV;
         exp_hi[i] = hi * TDIV;
      end
      repeat (5000) @(posedge hclk);
      for (int i = 0; i < 8; i++) snap[i] = route.rises[i];
      repeat (4500) @(posedge hclk);
      ahb(1'b0, REG_STATUS, 32'h0, r);
      chk(r & 32'h0000_0038, 32'h0000_0028);
      for (int i = 0; i < 8; i++)
      begin
         if (i inside {[3:5]})
            chk(32'(route.rises[i] - snap[i]), 32'h0);
         else
         begin
            chk(32'(route.period[i]), 32'(exp_per[i]));
            chk(32'(route.high[i]), 32'(exp_hi[i]));
         end
      end
      n = route.rises[0];
      for (int k = 0; k < 3000 && route.rises[0] == n; k++) @(posedge hclk);
      repeat (8) @(posedge hclk);
      wrc(REG_PCT, 32'd95);
      for (int k = 0; k < 3000 && aux[0] === 1'b1; k++) @(posedge hclk);
      @(posedge hclk);
      chk(32'(route.high[0]), 32'(exp_hi[0]));
      repeat (4500) @(posedge hclk);
      chk(32'(route.high[0]), 32'(exp_per[0] / TDIV * 95 / PCT_FULL * TDIV));
      wrc(REG_RATE, 32'h0);
      repeat (4500) @(posedge hclk);
      snap[0] = route.rises[0];
      repeat (2100) @(posedge hclk);
      ahb(1'b0, REG_STATUS, 32'h0, r);
      chk((r & 32'h0000_0001) | 32'(route.rises[0] - snap[0]), 32'h0);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      chk({24'h00_0000, ext, aux}, 32'h0);
      hresetn <= 1'b1;
      @(posedge hclk);
      rdc(CH_STRIDE + REG_CTRL, 32'h0);
      print_verdict();
   end
endmodule
